// ### omcs_host.sv
// Purpose: host controller model driving control pins and the two-wire bus
// Assumes: data line resolved outside with a pull-up
// Notes:   bus runs far above the field rate to keep the run short

`timescale 1ns/1ns
`default_nettype none

module omcs_host (
   input  wire logic mclk_in,          // pacing clock
   input  wire logic sda_in,           // resolved data line
   output logic      scl_out,          // serial clock, idles high
   output logic      sda_rel_out,      // high releases data line
   output logic      tx_disable_out,   // transmit-off pin
   output logic      rate_select_out   // bandwidth-choice pin
);
   // bus idle, pins low at time zero
   initial
   begin
      scl_out = 1'b1;
      sda_rel_out = 1'b1;
      tx_disable_out = 1'b0;
      rate_select_out = 1'b0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : tk

   task automatic pins(input logic t, input logic r);
      @(posedge mclk_in);
      tx_disable_out <= t;
      rate_select_out <= r;
   endtask : pins

   // data moves mid-low, sampled mid-high, so no edge race with the slave
   // 16 cycles a bit; the field limit is far slower, kept short here for run time
   task automatic bitx(input logic b, output logic r);
      tk(4);
      sda_rel_out <= b;
      tk(4);
      scl_out <= 1'b1;
      tk(4);
      r = sda_in;
      tk(4);
      scl_out <= 1'b0;
   endtask : bitx

   // also serves as repeated start from a low clock
   task automatic start();
      tk(4);
      sda_rel_out <= 1'b1;
      tk(4);
      scl_out <= 1'b1;
      tk(4);
      sda_rel_out <= 1'b0;
      tk(8);
      scl_out <= 1'b0;
   endtask : start

   task automatic stop();
      tk(4);
      sda_rel_out <= 1'b0;
      tk(4);
      scl_out <= 1'b1;
      tk(8);
      sda_rel_out <= 1'b1;
      tk(8);
   endtask : stop

   task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(m, a);
   endtask : xbyte

   task automatic wr(input logic [7:0] dev, input logic [7:0] off, input logic [15:0] d, input int n,
                     output logic nak);
      logic [7:0] q;
      logic       a;
      start();
      xbyte(dev, 1'b1, q, nak);
      xbyte(off, 1'b1, q, a);
      nak |= a;
      if (n == 2)
         xbyte(d[15:8], 1'b1, q, a);
      xbyte(d[7:0], 1'b1, q, a);
      stop();
   endtask : wr

   // one byte read, ended by a master refusal
   task automatic rd(input logic [7:0] dev, input logic [7:0] off, output logic [7:0] q, output logic nak);
      logic [7:0] x;
      logic       a;
      start();
      xbyte(dev, 1'b1, x, nak);
      xbyte(off, 1'b1, x, a);
      nak |= a;
      start();
      xbyte(dev | 8'h01, 1'b1, x, a);
      nak |= a;
      xbyte(8'hFF, 1'b1, q, a);
      stop();
   endtask : rd
endmodule : omcs_host

`default_nettype wire

// ### omcs_pkg.sv
// Purpose: shared constants and types of the optical module control/status logic
// Assumes: 100 MHz core clock
// Notes:   times are kept in their own unit; cycle counts derive from them

package omcs_pkg;

   // core clock
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
   localparam int unsigned CLK_PER_MS    = CLK_HZ / 1_000;

   // timing figures in their printed units
   localparam int unsigned T_RESET_US    = 10;    // least disable hold to clear a fault
   localparam int unsigned T_INIT_MS     = 300;   // longest initialization time
   localparam int unsigned T_DATA_MS     = 1000;  // longest time to data ready

   // derived cycle counts: a least time rounds up, a longest time rounds down
   localparam int unsigned T_RESET_CYC   = (T_RESET_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned T_INIT_CYC    = T_INIT_MS * CLK_PER_MS;
   localparam int unsigned T_DATA_CYC    = T_DATA_MS * CLK_PER_MS;
   localparam int unsigned TMR_W         = 32;

   // two-wire addressing
   localparam logic [6:0]  DEV_ID_PAGE   = 7'h50;  // identification page, 0xA0 on the wire
   localparam logic [6:0]  DEV_DIAG_PAGE = 7'h51;  // diagnostic page, 0xA2 on the wire
   localparam logic [7:0]  CTRL_OFS      = 8'h6E;  // optional_control_status
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   localparam int unsigned SYNC_W        = 6;

   // optional_control_status layout, reserved bits read as zero
   typedef struct packed {
      logic       rsv_hi;        // bit 7
      logic       soft_txdis;    // bit 6, read/write
      logic [1:0] rsv_mid;       // bits 5:4
      logic       soft_rate;     // bit 3, read/write
      logic       fault;         // bit 2, read only
      logic       lost;          // bit 1, read only
      logic       data_ready;    // bit 0, read only
   } omcs_ctrl_t;

   // inputs from outside the clock domain, carried through one synchroniser
   typedef struct packed {
      logic tx_disable;
      logic rate_select;
      logic laser_fault;
      logic sig_present;
      logic scl;
      logic sda;
   } omcs_in_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_DEV, ST_DACK, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
   } omcs_state_t;

endpackage : omcs_pkg

// ### omcs_properties.sv
// Purpose: port timing checks of the optical module control/status block
// Assumes: 100 MHz clock, ce_in dropped by the bench only briefly and only around a rate pin change
// Notes:   bounds longer than 1000 cycles are tightened to 1000 cycles

`timescale 1ns/1ns
`default_nettype none

module omcs_props #(
   parameter int unsigned INIT_CYC = omcs_pkg::T_INIT_CYC  // power-on settle
) (
   input wire logic mclk_in,                  // core clock
   input wire logic rstn_in,                  // reset, active low
   input wire logic tx_disable_in,            // transmit-off pin
   input wire logic rate_select_in,           // bandwidth-choice pin
   input wire logic laser_fault_in,           // fault sensor
   input wire logic sig_present_in,           // signal detector
   input wire logic sda_oen_out,              // data enable, low drives
   input wire logic laser_en_out,             // optical output on
   input wire logic tx_fault_out,             // laser-fault pin
   input wire logic receive_signal_lost_out,  // signal-lost pin
   input wire logic rate_cfg_out              // active rate
);
   logic [31:0] up_reg;  // cycles since reset release

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   // saturates so a long run never wraps into the settle window
   always_ff @(posedge mclk_in or negedge rstn_in)
      if (!rstn_in)
         up_reg <= 32'h0;
      else if (up_reg != 32'hFFFFFFFF)
         up_reg <= up_reg + 32'h1;

   pin_off_a: assert property ($rose(tx_disable_in) |-> ##[1:1000] !laser_en_out)
      else $error("laser stayed on after pin disable");
   init_dark_a: assert property (up_reg < INIT_CYC |-> !laser_en_out)
      else $error("laser on before settle time");
   fault_pin_a: assert property (laser_en_out && $rose(laser_fault_in) |-> ##[1:1000] tx_fault_out)
      else $error("fault pin late");
   fault_dark_a: assert property (tx_fault_out |-> !laser_en_out)
      else $error("laser on while fault latched");
   lost_set_a: assert property ($fell(sig_present_in) |-> ##[1:1000] receive_signal_lost_out)
      else $error("signal-lost pin late");
   lost_clear_a: assert property ($rose(sig_present_in) |-> ##[1:1000] !receive_signal_lost_out)
      else $error("signal-lost pin stuck");
   rate_pin_a: assert property ($rose(rate_select_in) |-> ##[1:1000] rate_cfg_out)
      else $error("rate pin ignored");
   off_hold_a: assert property (tx_disable_in [*4] |-> !laser_en_out)
      else $error("pin disable not honoured");

   // main scenarios reached
   cover property ($rose(tx_fault_out));
   cover property ($fell(tx_fault_out));
   cover property (!sda_oen_out);
endmodule : omcs_props

bind omcs_top omcs_props #(.INIT_CYC(INIT_CYC)) u_props (
   .mclk_in, .rstn_in, .tx_disable_in, .rate_select_in, .laser_fault_in, .sig_present_in,
   .sda_oen_out, .laser_en_out, .tx_fault_out, .receive_signal_lost_out, .rate_cfg_out
);

`default_nettype wire

// ### omcs_sync.sv
// Purpose: two-flop synchroniser for a group of asynchronous inputs
// Assumes: inputs change slower than the core clock
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ns
`default_nettype none

module omcs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         mclk_in,    // core clock
   input  wire logic         rstn_in,    // async reset, active low
   input  wire logic         ce_in,      // clock enable
   input  wire logic [W-1:0] async_in,   // raw inputs
   output logic      [W-1:0] sync_out    // synchronised inputs
);

   logic [W-1:0] meta_reg;

   // one pair of flops per bit
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge mclk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else if (ce_in)
            begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule : omcs_sync

`default_nettype wire

// ### omcs_tmr.sv
// Purpose: run-while-high timer with a sticky done flag
// Assumes: limit is at least one
// Notes:   dropping run clears the count and the flag

`timescale 1ns/1ns
`default_nettype none

module omcs_tmr #(
   parameter int unsigned W = 32
) (
   input  wire logic         mclk_in,   // core clock
   input  wire logic         rstn_in,   // async reset, active low
   input  wire logic         ce_in,     // clock enable
   input  wire logic         run_in,    // count while high
   input  wire logic [W-1:0] lim_in,    // cycles to count
   output logic              done_out   // limit reached, level
);

   logic [W-1:0] cnt_reg;

   // count up, stop at the limit
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cnt_reg  <= '0;
         done_out <= 1'b0;
      end
      else if (ce_in)
      begin
         if (!run_in)
         begin
            cnt_reg  <= '0;
            done_out <= 1'b0;
         end
         else if (cnt_reg >= lim_in)
            done_out <= 1'b1;
         else
            cnt_reg <= W'(cnt_reg + 1'b1);
      end
   end

endmodule : omcs_tmr

`default_nettype wire

// ### omcs_top.sv
// Purpose: control and status timing of a pluggable optical module, with its two-wire slave
// Assumes: all pins and sensor levels are asynchronous to mclk_in
// Notes:   only the control/status byte is implemented; other bytes read zero

`timescale 1ns/1ns
`default_nettype none

module omcs_top #(
   parameter int unsigned INIT_CYC = omcs_pkg::T_INIT_CYC,  // power-on settle
   parameter int unsigned DRDY_CYC = omcs_pkg::T_DATA_CYC   // monitor settle
) (
   input  wire logic mclk_in,                  // core clock, 100 MHz
   input  wire logic rstn_in,                  // power-on reset, active low
   input  wire logic ce_in,                    // clock enable, freezes all state
   input  wire logic tx_disable_in,            // transmit-off pin
   input  wire logic rate_select_in,           // bandwidth-choice pin
   input  wire logic laser_fault_in,           // laser fault sensor, high on fault
   input  wire logic sig_present_in,           // optical signal detector, high when valid
   input  wire logic scl_in,                   // two-wire serial clock
   input  wire logic sda_in,                   // two-wire data, input side
   output logic      sda_out,                  // two-wire data, output level
   output logic      sda_oen_out,              // two-wire data enable, low drives
   output logic      laser_en_out,             // optical output enabled
   output logic      tx_fault_out,             // laser-fault pin
   output logic      receive_signal_lost_out,  // signal-lost pin
   output logic      rate_cfg_out              // active bandwidth configuration
);

   omcs_pkg::omcs_in_t    raw, syn;
   omcs_pkg::omcs_ctrl_t  ctrl;
   omcs_pkg::omcs_state_t st_reg;
   logic       scl_d_reg, sda_d_reg;
   logic       s_rise, s_fall, s_start, s_stop;
   logic       pin_dis_d_reg;
   logic       init_done, drdy_done, hold_ok;
   logic       fault_reg, soft_txdis_reg, soft_rate_reg;
   logic       pend_reg;
   logic [7:0] pend_val_reg;
   logic       page_reg;
   logic [2:0] bit_reg;
   logic [7:0] sh_reg, addr_reg;
   logic [7:0] byte_in;

   // read decode of the diagnostic page; identification bytes read zero
   function automatic logic [7:0] rd_fn(input logic diag, input logic [7:0] ofs,
                                        input logic [7:0] ctl);
      rd_fn = (diag && ofs == omcs_pkg::CTRL_OFS) ? ctl : 8'h00;
   endfunction : rd_fn

   // every outside level passes two flops before use
   assign raw = '{tx_disable:  tx_disable_in,
                  rate_select: rate_select_in,
                  laser_fault: laser_fault_in,
                  sig_present: sig_present_in,
                  scl:         scl_in,
                  sda:         sda_in};

   omcs_sync #(.W(omcs_pkg::SYNC_W)) u_sync (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .async_in (raw),
      .sync_out (syn)
   );

   // power-on initialization window
   omcs_tmr #(.W(omcs_pkg::TMR_W)) u_init (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .run_in   (1'b1),
      .lim_in   (32'(INIT_CYC)),
      .done_out (init_done)
   );

   // analog monitor settle time ahead of data ready
   omcs_tmr #(.W(omcs_pkg::TMR_W)) u_drdy (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .run_in   (1'b1),
      .lim_in   (32'(DRDY_CYC)),
      .done_out (drdy_done)
   );

   // disable pin hold time; a shorter pulse leaves a latched fault in place
   omcs_tmr #(.W(omcs_pkg::TMR_W)) u_hold (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .run_in   (syn.tx_disable),
      .lim_in   (32'(omcs_pkg::T_RESET_CYC)),
      .done_out (hold_ok)
   );

   // bus line and disable pin edges, seen on synchronised copies only
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         scl_d_reg     <= 1'b1;
         sda_d_reg     <= 1'b1;
         pin_dis_d_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         scl_d_reg     <= syn.scl;
         sda_d_reg     <= syn.sda;
         pin_dis_d_reg <= syn.tx_disable;
      end
   end

   // sampling at 100 MHz leaves wide margin on a 100 kHz bus
   assign s_rise  = syn.scl & ~scl_d_reg;
   assign s_fall  = ~syn.scl & scl_d_reg;
   assign s_start = syn.scl & scl_d_reg & sda_d_reg & ~syn.sda;
   assign s_stop  = syn.scl & scl_d_reg & ~sda_d_reg & syn.sda;
   assign byte_in = {sh_reg[6:0], syn.sda};

   // latched laser fault: set wins, cleared only by a long enough disable pulse
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         fault_reg <= 1'b0;
      else if (ce_in)
      begin
         if (syn.laser_fault && init_done)
            fault_reg <= 1'b1;
         else if (pin_dis_d_reg && !syn.tx_disable && hold_ok)
            fault_reg <= 1'b0;
      end
   end

   // pin outputs follow within a few cycles of the synchronised cause
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         laser_en_out            <= 1'b0;
         tx_fault_out            <= 1'b0;
         receive_signal_lost_out <= 1'b1;
         rate_cfg_out            <= 1'b0;
      end
      else if (ce_in)
      begin
         // output held dark until init completes; pin or soft bit each shut it
         laser_en_out <= init_done & ~fault_reg
                         & ~(syn.tx_disable | soft_txdis_reg);
         tx_fault_out <= fault_reg;
         receive_signal_lost_out <= ~syn.sig_present;
         rate_cfg_out <= syn.rate_select | soft_rate_reg;
      end
   end

   // status byte as read back over the bus
   always_comb
   begin
      ctrl            = omcs_pkg::CTRL_RST;
      ctrl.soft_txdis = soft_txdis_reg;
      ctrl.soft_rate  = soft_rate_reg;
      ctrl.fault      = fault_reg;
      ctrl.lost       = ~syn.sig_present;
      ctrl.data_ready = drdy_done;
   end

   // soft bits change only at the stop that ends a write
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         soft_txdis_reg <= 1'b0;
         soft_rate_reg  <= 1'b0;
      end
      else if (ce_in && s_stop && pend_reg)
      begin
         soft_txdis_reg <= pend_val_reg[6];
         soft_rate_reg  <= pend_val_reg[3];
      end
   end

   // two-wire slave sequencing; the bus is live straight out of reset
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_reg       <= omcs_pkg::ST_IDLE;
         bit_reg      <= 3'h0;
         sh_reg       <= 8'h00;
         addr_reg     <= 8'h00;
         page_reg     <= 1'b0;
         pend_reg     <= 1'b0;
         pend_val_reg <= 8'h00;
         sda_oen_out  <= 1'b1;
         sda_out      <= 1'b0;
      end
      else if (ce_in)
      begin
         if (s_start)
         begin
            st_reg      <= omcs_pkg::ST_DEV;
            bit_reg     <= 3'h0;
            sda_oen_out <= 1'b1;
         end
         else if (s_stop)
         begin
            st_reg      <= omcs_pkg::ST_IDLE;
            pend_reg    <= 1'b0;
            sda_oen_out <= 1'b1;
         end
         else if (s_rise)
         begin
            case (st_reg)
               omcs_pkg::ST_DEV:
               begin
                  sh_reg  <= byte_in;
                  bit_reg <= 3'(bit_reg + 1'b1);
                  if (bit_reg == omcs_pkg::BIT_LAST)
                  begin
                     if (byte_in[7:1] == omcs_pkg::DEV_ID_PAGE || byte_in[7:1] == omcs_pkg::DEV_DIAG_PAGE)
                     begin
                        st_reg   <= omcs_pkg::ST_DACK;
                        page_reg <= byte_in[1];
                     end
                     else
                        st_reg <= omcs_pkg::ST_IDLE;
                  end
               end
               omcs_pkg::ST_DACK:
               begin
                  if (sh_reg[0])
                  begin
                     st_reg <= omcs_pkg::ST_RD;
                     sh_reg <= rd_fn(page_reg, addr_reg, ctrl);
                  end
                  else
                     st_reg <= omcs_pkg::ST_ADDR;
               end
               omcs_pkg::ST_ADDR:
               begin
                  sh_reg  <= byte_in;
                  bit_reg <= 3'(bit_reg + 1'b1);
                  if (bit_reg == omcs_pkg::BIT_LAST)
                  begin
                     addr_reg <= byte_in;
                     st_reg   <= omcs_pkg::ST_AACK;
                  end
               end
               omcs_pkg::ST_AACK, omcs_pkg::ST_WACK:
                  st_reg <= omcs_pkg::ST_WR;
               omcs_pkg::ST_WR:
               begin
                  sh_reg  <= byte_in;
                  bit_reg <= 3'(bit_reg + 1'b1);
                  if (bit_reg == omcs_pkg::BIT_LAST)
                  begin
                     // held until stop so the whole burst lands at once
                     if (page_reg && addr_reg == omcs_pkg::CTRL_OFS)
                     begin
                        pend_reg     <= 1'b1;
                        pend_val_reg <= byte_in;
                     end
                     addr_reg <= 8'(addr_reg + 1'b1);
                     st_reg   <= omcs_pkg::ST_WACK;
                  end
               end
               omcs_pkg::ST_RD:
               begin
                  sh_reg  <= {sh_reg[6:0], 1'b0};
                  bit_reg <= 3'(bit_reg + 1'b1);
                  if (bit_reg == omcs_pkg::BIT_LAST)
                  begin
                     addr_reg <= 8'(addr_reg + 1'b1);
                     st_reg   <= omcs_pkg::ST_RACK;
                  end
               end
               omcs_pkg::ST_RACK:
               begin
                  // a master nack ends the read
                  if (syn.sda)
                     st_reg <= omcs_pkg::ST_IDLE;
                  else
                  begin
                     st_reg <= omcs_pkg::ST_RD;
                     sh_reg <= rd_fn(page_reg, addr_reg, ctrl);
                  end
               end
               default:
                  st_reg <= st_reg;
            endcase
         end
         else if (s_fall)
         begin
            // data changes only while the clock is low
            case (st_reg)
               omcs_pkg::ST_DACK, omcs_pkg::ST_AACK, omcs_pkg::ST_WACK:
                  sda_oen_out <= 1'b0;
               omcs_pkg::ST_RD:
                  sda_oen_out <= sh_reg[7];
               default:
                  sda_oen_out <= 1'b1;
            endcase
         end
      end
   end

endmodule : omcs_top

`default_nettype wire

// ### tb_optical_module_control_status.sv
// Purpose: self-checking bench of the control/status block
// Assumes: shortened settle counts 50 and 200
// Notes:   sensors driven here, pins and bus by the host model

`timescale 1ns/1ns
`default_nettype none

module tb_optical_module_control_status;
   logic       mclk_in        = 1'b0;
   logic       rstn_in        = 1'b0;
   logic       laser_fault_in = 1'b0;
   logic       ce             = 1'b1;
   logic       sig_present_in = 1'b1;
   wire logic  scl, sda_rel, txd, rate, sda_w, sda_o, sda_oen, las, flt, lost, rcfg;
   logic [7:0] q;
   logic       nak;
   int         err_count  = 0;
   int         n_compared = 0;
   int         cyc        = 0;
   logic [7:0]  offs [3] = '{8'h6E, 8'h6E, 8'h6D};
   logic [15:0] vals [3] = '{16'h0040, 16'h0008, 16'hFF40};
   int          lens [3] = '{1, 1, 2};
   int          hold [2] = '{100, 1010};

   always #5 mclk_in = ~mclk_in;

   // open-drain data line with pull-up
   assign sda_w = sda_rel & (sda_oen | sda_o);

   omcs_top #(.INIT_CYC(50), .DRDY_CYC(200)) u_dut (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce), .tx_disable_in(txd), .rate_select_in(rate),
      .laser_fault_in(laser_fault_in), .sig_present_in(sig_present_in), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oen_out(sda_oen), .laser_en_out(las), .tx_fault_out(flt),
      .receive_signal_lost_out(lost), .rate_cfg_out(rcfg)
   );

   omcs_host u_h (
      .mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(sda_rel),
      .tx_disable_out(txd), .rate_select_out(rate)
   );

   task automatic tk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : tk

   task automatic chk1(input logic e, input logic g);
      @(negedge mclk_in);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR at %0t exp %h got %h", $time, e, g);
      end
   endtask : chk1

   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      @(negedge mclk_in);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR at %0t exp %h got %h", $time, e, g);
      end
   endtask : chk8

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // hang guard, well above the expected run length
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   initial
   begin
      tk(2);
      rstn_in <= 1'b1;
      tk(20);
      chk1(1'b0, las);
      u_h.rd(8'hA2, 8'h6E, q, nak);
      chk1(1'b0, nak);
      chk8(8'h01, q);
      chk1(1'b1, las);
      $display("test power-on done");
      u_h.pins(1'b1, 1'b0);
      tk(5);
      chk1(1'b0, las);
      u_h.pins(1'b0, 1'b1);
      tk(5);
      chk1(1'b1, las);
      chk1(1'b1, rcfg);
      u_h.pins(1'b0, 1'b0);
      tk(5);
      chk1(1'b0, rcfg);
      $display("test pins done");
      // soft bits: single writes and a two-byte burst ending on the live byte
      for (int i = 0; i < 3; i++)
      begin
         u_h.wr(8'hA2, offs[i], vals[i], lens[i], nak);
         chk1(1'b0, nak);
         chk1(~vals[i][6], las);
         chk1(vals[i][3], rcfg);
         u_h.rd(8'hA2, 8'h6E, q, nak);
         chk8(vals[i][7:0] | 8'h01, q);
         u_h.wr(8'hA2, 8'h6E, 16'h0000, 1, nak);
         chk1(1'b1, las);
         chk1(1'b0, rcfg);
      end
      $display("test soft bits done");
      tk(1);
      sig_present_in <= 1'b0;
      tk(5);
      chk1(1'b1, lost);
      u_h.rd(8'hA2, 8'h6E, q, nak);
      chk8(8'h03, q);
      tk(1);
      sig_present_in <= 1'b1;
      tk(5);
      chk1(1'b0, lost);
      u_h.rd(8'hA2, 8'h6E, q, nak);
      chk8(8'h01, q);
      $display("test signal loss done");
      tk(1);
      laser_fault_in <= 1'b1;
      tk(6);
      chk1(1'b1, flt);
      chk1(1'b0, las);
      u_h.rd(8'hA2, 8'h6E, q, nak);
      chk8(8'h05, q);
      tk(1);
      laser_fault_in <= 1'b0;
      // a short disable pulse leaves the latch set, a long one clears it
      for (int i = 0; i < 2; i++)
      begin
         u_h.pins(1'b1, 1'b0);
         tk(hold[i]);
         u_h.pins(1'b0, 1'b0);
         tk(6);
         chk1(i == 0, flt);
         chk1(i == 1, las);
      end
      $display("test fault done");
      u_h.wr(8'hA4, 8'h6E, 16'h0040, 1, nak);
      chk1(1'b1, nak);
      chk1(1'b1, las);
      u_h.rd(8'hA0, 8'h6E, q, nak);
      chk1(1'b0, nak);
      chk8(8'h00, q);
      $display("test refusal done");
      // a low enable freezes the synchronisers, so a pin change waits for it
      tk(1);
      ce <= 1'b0;
      u_h.pins(1'b0, 1'b1);
      tk(5);
      chk1(1'b0, rcfg);
      tk(1);
      ce <= 1'b1;
      tk(5);
      chk1(1'b1, rcfg);
      u_h.pins(1'b0, 1'b0);
      tk(5);
      chk1(1'b0, rcfg);
      $display("test clock enable done");
      report_and_stop();
   end
endmodule : tb_optical_module_control_status

`default_nettype wire
